// file: tpc_pkg.sv
package tpc_pkg;

  // ----------------------------------------------------------------------
  // Object indices of the register map
  // ----------------------------------------------------------------------
  localparam logic [15:0] TPC_IDX_CONFIG   = 16'h60B8;
  localparam logic [15:0] TPC_IDX_STATUS   = 16'h60B9;
  localparam logic [15:0] TPC_IDX_P1_RISE  = 16'h60BA;
  localparam logic [15:0] TPC_IDX_P1_FALL  = 16'h60BB;

  // ----------------------------------------------------------------------
  // Configuration word field positions
  // ----------------------------------------------------------------------
  localparam int TPC_CFG_CH1_EN    = 0;
  localparam int TPC_CFG_CH1_CONT  = 1;
  localparam int TPC_CFG_CH1_SRC   = 2;
  localparam int TPC_CFG_CH1_RISE  = 4;
  localparam int TPC_CFG_CH1_FALL  = 5;
  localparam int TPC_CFG_CH2_EN    = 8;
  localparam int TPC_CFG_CH2_CONT  = 9;
  localparam int TPC_CFG_CH2_SRC   = 10;
  localparam int TPC_CFG_CH2_RISE  = 12;
  localparam int TPC_CFG_CH2_FALL  = 13;

  // ----------------------------------------------------------------------
  // Status word field positions
  // ----------------------------------------------------------------------
  localparam int TPC_STS_CH1_EN    = 0;
  localparam int TPC_STS_CH1_RISE  = 1;
  localparam int TPC_STS_CH1_FALL  = 2;
  localparam int TPC_STS_CH2_EN    = 8;
  localparam int TPC_STS_CH2_RISE  = 9;
  localparam int TPC_STS_CH2_FALL  = 10;

  // User-defined bits 6,7,14,15: stored and echoed, no effect
  localparam logic [15:0] TPC_USER_MASK    = 16'hC0C0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] TPC_CONFIG_RESET = 16'h0000;
  localparam logic [31:0] TPC_POS_RESET    = 32'h0000_0000;

  // Trigger source codes
  typedef enum logic [1:0] {
    TPC_SRC_PROBE = 2'h0,
    TPC_SRC_ZERO  = 2'h1,
    TPC_SRC_AUX   = 2'h2,
    TPC_SRC_RSVD  = 2'h3
  } tpc_src_type;

endpackage : tpc_pkg

// file: tpc_capture.sv
module tpc_capture
  import tpc_pkg::*;
#(
  parameter int POS_WIDTH = 32
) (
  input  wire logic                  clk_in,          // System clock, 20 MHz
  input  wire logic                  arst_n_in,       // Async reset, active low
  input  wire logic [POS_WIDTH-1:0]  position_in,     // Main position feedback, user units
  input  wire logic                  homing_in,       // Homing motion mode active
  input  wire logic                  enc_index_in,    // Encoder counter index
  input  wire logic                  enc_strobe_in,   // Encoder counter strobe
  input  wire logic                  enc_zero_in,     // Zero impulse of position encoder
  input  wire logic [1:0]            aux_src_in,      // Auxiliary sources, sub-index 1 and 2
  input  wire logic                  obj_wr_in,       // Object write strobe
  input  wire logic [15:0]           obj_index_in,    // Object index
  input  wire logic [31:0]           obj_wdata_in,    // Object write data
  output logic      [31:0]           obj_rdata_out,   // Object read data
  output logic                       obj_ack_out,     // Index is mapped
  output logic      [15:0]           config_out,      // Function config word
  output logic      [15:0]           status_out,      // Status word
  output logic signed [31:0]         p1_rise_pos_out, // Channel 1 rising position
  output logic signed [31:0]         p1_fall_pos_out  // Channel 1 falling position
);
  import tpc_pkg::*;

  // Both channels share one decode and one capture loop. Only channel 1 owns
  // position registers in this block. The latched positions are cleared at
  // reset so that a read before the first capture gives a defined value
  // rather than whatever the flops held at power-up.

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0]          config_reg, config_next;
  logic [1:0]           in_reg, in_next;         // Previous sampled inputs
  logic [1:0]           armed_reg, armed_next;   // Rising seen, falling may fire
  logic [1:0]           rise_st_reg, rise_st_next;
  logic [1:0]           fall_st_reg, fall_st_next;
  logic [31:0]          p1r_reg, p1r_next;
  logic [31:0]          p1f_reg, p1f_next;

  logic [1:0]           ch_en, rise_en, fall_en;
  logic [1:0]           sel_in, rise_edge, fall_edge;
  logic [1:0]           src [2];
  logic [31:0]          pos32;
  logic [15:0]          wdata_lo;        // Config part of the write word, for the checks

  // Widen or trim the feedback to the object width
  assign pos32 = 32'(signed'(position_in));

  // Low half of the write word, the only part the config object takes
  assign wdata_lo = obj_wdata_in[15:0];

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  // Continuous bits 1 and 9 and user bits never reach the decode
  always_comb begin
    ch_en[0]   = config_reg[TPC_CFG_CH1_EN] & ~homing_in;
    ch_en[1]   = config_reg[TPC_CFG_CH2_EN] & ~homing_in;
    rise_en[0] = config_reg[TPC_CFG_CH1_RISE];
    rise_en[1] = config_reg[TPC_CFG_CH2_RISE];
    fall_en[0] = config_reg[TPC_CFG_CH1_FALL];
    fall_en[1] = config_reg[TPC_CFG_CH2_FALL];
    src[0]     = config_reg[TPC_CFG_CH1_SRC+1:TPC_CFG_CH1_SRC];
    src[1]     = config_reg[TPC_CFG_CH2_SRC+1:TPC_CFG_CH2_SRC];
  end

  // Source mux; reserved code gives a quiet input so nothing fires
  // Switching the source while a channel is enabled compares the new line with
  // the old line's last sample, so switch sources with the channel off
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      unique case (tpc_src_type'(src[c]))
        TPC_SRC_PROBE: sel_in[c] = (c == 0) ? enc_index_in : enc_strobe_in;
        TPC_SRC_ZERO:  sel_in[c] = enc_zero_in;
        TPC_SRC_AUX:   sel_in[c] = aux_src_in[c];
        TPC_SRC_RSVD:  sel_in[c] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Edge detection and capture state
  // ----------------------------------------------------------------------
  // Edge pulses against the previous sample. The sample resets low, so a line
  // already high at reset release looks like one rising edge; the channels
  // are still disabled then, so nothing is captured and nothing is armed.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rise_edge[c] = sel_in[c] & ~in_reg[c];
      fall_edge[c] = ~sel_in[c] & in_reg[c];
    end
  end

  // Next capture state; the line is sampled on every edge, enabled or not
  always_comb begin
    in_next      = sel_in;
    armed_next   = armed_reg;
    rise_st_next = rise_st_reg;
    fall_st_next = fall_st_reg;
    p1r_next     = p1r_reg;
    p1f_next     = p1f_reg;
    for (int c = 0; c < 2; c++) begin
      if (!ch_en[c]) begin
        // Flags drop, positions are left alone
        rise_st_next[c] = 1'b0;
        fall_st_next[c] = 1'b0;
        armed_next[c]   = 1'b0;
      end else begin
        // Falling only after a rising edge, so a high input skips one fall
        if (rise_edge[c]) begin
          armed_next[c] = 1'b1;
        end
        if (!rise_en[c]) begin
          rise_st_next[c] = 1'b0;
        end else if (rise_edge[c] && !rise_st_reg[c]) begin
          rise_st_next[c] = 1'b1;
          if (c == 0) begin
            p1r_next = pos32;
          end
        end
        if (!fall_en[c]) begin
          fall_st_next[c] = 1'b0;
        end else if (fall_edge[c] && armed_reg[c] && !fall_st_reg[c]) begin
          fall_st_next[c] = 1'b1;
          if (c == 0) begin
            p1f_next = pos32;
          end
        end
      end
    end
  end

  // Object write; only the config object is writable
  always_comb begin
    config_next = config_reg;
    if (obj_wr_in && obj_index_in == TPC_IDX_CONFIG) begin
      config_next = obj_wdata_in[15:0];
    end
  end

  // Config group: the only state that the object bus writes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      config_reg <= TPC_CONFIG_RESET;
    end else begin
      config_reg <= config_next;
    end
  end

  // Capture group: sampled lines, arming, stored flags and positions
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_reg      <= 2'h0;
      armed_reg   <= 2'h0;
      rise_st_reg <= 2'h0;
      fall_st_reg <= 2'h0;
      p1r_reg     <= TPC_POS_RESET;
      p1f_reg     <= TPC_POS_RESET;
    end else begin
      in_reg      <= in_next;
      armed_reg   <= armed_next;
      rise_st_reg <= rise_st_next;
      fall_st_reg <= fall_st_next;
      p1r_reg     <= p1r_next;
      p1f_reg     <= p1f_next;
    end
  end

  // ----------------------------------------------------------------------
  // Status and read path
  // ----------------------------------------------------------------------
  // Enabled bits follow config combinationally, so they clear in the same cycle
  always_comb begin
    status_out                   = config_reg & TPC_USER_MASK;
    status_out[TPC_STS_CH1_EN]   = ch_en[0];
    status_out[TPC_STS_CH1_RISE] = rise_st_reg[0];
    status_out[TPC_STS_CH1_FALL] = fall_st_reg[0];
    status_out[TPC_STS_CH2_EN]   = ch_en[1];
    status_out[TPC_STS_CH2_RISE] = rise_st_reg[1];
    status_out[TPC_STS_CH2_FALL] = fall_st_reg[1];
  end

  assign config_out      = config_reg;
  assign p1_rise_pos_out = p1r_reg;
  assign p1_fall_pos_out = p1f_reg;

  // Reads are combinational so a poll sees the object while its index stands;
  // 16-bit objects sit in the low half with the upper half zero
  // Unmapped indices read zero with no acknowledge
  always_comb begin
    obj_ack_out   = 1'b1;
    obj_rdata_out = 32'h0000_0000;
    unique case (obj_index_in)
      TPC_IDX_CONFIG:  obj_rdata_out = {16'h0000, config_reg};
      TPC_IDX_STATUS:  obj_rdata_out = {16'h0000, status_out};
      TPC_IDX_P1_RISE: obj_rdata_out = p1r_reg;
      TPC_IDX_P1_FALL: obj_rdata_out = p1f_reg;
      default:         obj_ack_out   = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  // Channel 1 is checked on positions as well as flags; channel 2 has flags
  // only, since its position objects are not part of this block
  rise_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ch_en[0] && rise_en[0] && rise_edge[0] && !rise_st_reg[0])
      |=> (rise_st_reg[0] && p1r_reg == $past(pos32)))
    else $error("rising capture missed");

  fall_unarmed_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!armed_reg[0] && !fall_st_reg[0]) |=> !fall_st_reg[0] || $past(ch_en[0] && armed_reg[0]))
    else $error("falling captured without rising");

  rise_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!rise_en[0]) |=> (!rise_st_reg[0] && $stable(p1r_reg)))
    else $error("rising flag kept or position changed");

  disable_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!ch_en[1]) |=> (!rise_st_reg[1] && !fall_st_reg[1]))
    else $error("channel 2 flags not cleared");

  pos_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(ch_en[0] && fall_en[0] && fall_edge[0]) |=> $stable(p1f_reg))
    else $error("falling position changed without capture");

  homing_block_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    homing_in |-> (!status_out[TPC_STS_CH1_EN] && !status_out[TPC_STS_CH2_EN]))
    else $error("capture enabled in homing");

  status_en_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    status_out[TPC_STS_CH1_EN] == (config_reg[TPC_CFG_CH1_EN] && !homing_in))
    else $error("channel 1 enabled bit wrong");

  single_shot_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rise_st_reg[0] && rise_en[0] && ch_en[0]) |=> $stable(p1r_reg))
    else $error("second rising capture taken");

  fall_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ch_en[0] && fall_en[0] && fall_edge[0] && armed_reg[0] && !fall_st_reg[0])
      |=> (fall_st_reg[0] && p1f_reg == $past(pos32)))
    else $error("falling capture missed");

  rise2_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ch_en[1] && rise_en[1] && rise_edge[1] && !rise_st_reg[1]) |=> rise_st_reg[1])
    else $error("channel 2 rising capture missed");

  fall2_capture_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (ch_en[1] && fall_en[1] && fall_edge[1] && armed_reg[1] && !fall_st_reg[1]) |=> fall_st_reg[1])
    else $error("channel 2 falling capture missed");

  fall2_unarmed_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!armed_reg[1] && !fall_st_reg[1]) |=> !fall_st_reg[1])
    else $error("channel 2 falling captured without rising");

  rise2_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!rise_en[1]) |=> !rise_st_reg[1])
    else $error("channel 2 rising flag kept");

  fall_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!fall_en[0]) |=> (!fall_st_reg[0] && $stable(p1f_reg)))
    else $error("falling flag kept or position changed");

  ch1_off_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!ch_en[0]) |=> (!rise_st_reg[0] && !fall_st_reg[0] && $stable(p1r_reg) && $stable(p1f_reg)))
    else $error("channel 1 flags kept or positions changed");

  rise_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !(ch_en[0] && rise_en[0] && rise_edge[0]) |=> $stable(p1r_reg))
    else $error("rising position changed without capture");

  status_rsvd_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (status_out[5:3] == 3'h0 && status_out[13:11] == 3'h0))
    else $error("reserved status bits set");

  user_echo_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ((status_out & TPC_USER_MASK) == (config_reg & TPC_USER_MASK)))
    else $error("user status bits differ from config");

  status2_en_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    status_out[TPC_STS_CH2_EN] == (config_reg[TPC_CFG_CH2_EN] && !homing_in))
    else $error("channel 2 enabled bit wrong");

  cfg_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (obj_wr_in && obj_index_in == TPC_IDX_CONFIG) |=> (config_out == $past(wdata_lo)))
    else $error("config write not taken");

  ro_write_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (obj_wr_in && obj_index_in != TPC_IDX_CONFIG) |=> $stable(config_reg))
    else $error("config changed by write to other object");

  rsvd_src_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (src[0] == TPC_SRC_RSVD && !rise_st_reg[0]) |=> !rise_st_reg[0])
    else $error("reserved source captured on channel 1");

  rsvd2_src_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (src[1] == TPC_SRC_RSVD && !rise_st_reg[1]) |=> !rise_st_reg[1])
    else $error("reserved source captured on channel 2");

  armed_off_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!ch_en[0]) |=> !armed_reg[0])
    else $error("falling capture armed while disabled");

  homing_flags_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    homing_in |=> (rise_st_reg == 2'h0 && fall_st_reg == 2'h0))
    else $error("stored flag kept in homing");

  fall_shot_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (fall_st_reg[0] && fall_en[0] && ch_en[0]) |=> $stable(p1f_reg))
    else $error("second falling capture taken");

  rise2_shot_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (rise_st_reg[1] && rise_en[1] && ch_en[1]) |=> rise_st_reg[1])
    else $error("channel 2 rising flag dropped while enabled");

  read_pos_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (obj_index_in == TPC_IDX_P1_RISE) |-> (obj_rdata_out == p1_rise_pos_out && obj_ack_out))
    else $error("rising position read wrong");

endmodule : tpc_capture

// file: tpc_enc_model.sv
module tpc_enc_model (
  input  wire logic        clk_in,    // System clock
  input  wire logic        wander_in, // Probe lines toggle at random
  input  wire logic [4:0]  lvl_in,    // Index, strobe, zero, aux levels
  output logic      [31:0] pos_out,   // Position feedback
  output logic      [4:0]  probe_out  // Probe lines as driven
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Encoder and probe lines
  // ----------------------------------------
  // Commands are taken at the edge and shown 2 ns later, one cycle behind the bench
  initial begin
    int k;
    logic [4:0] lvl;
    logic       wnd;
    pos_out   = 32'h0000_0000;
    probe_out = 5'h00;
    forever begin
      @(posedge clk_in);
      lvl = lvl_in;
      wnd = wander_in;
      #2;
      pos_out = $urandom;
      k = $urandom % 5;
      if (!wnd) probe_out = lvl;
      else if ($urandom % 8 == 0) probe_out[k] = ~probe_out[k];
    end
  end
endmodule : tpc_enc_model

// file: tpc_capture_tb_top.sv
module tpc_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tpc_pkg::*;
  logic clk_in = 0, arst_n_in = 0, hm = 0, w = 0, wander = 0, ack;
  logic        [15:0] ix = TPC_IDX_CONFIG, cf, st, mcf_reg;
  logic        [31:0] d = 32'h0000_0000, pos, rd;
  logic        [4:0]  lv = 5'h00, pr;
  logic        [1:0]  prv_reg, arm_reg, rf_reg, ff_reg;
  logic signed [31:0] p1r, p1f, mr_reg, mf_reg;
  int err_count = 0, tests_run = 0;

  always #25 clk_in = ~clk_in;

  tpc_enc_model enc (.clk_in(clk_in), .wander_in(wander), .lvl_in(lv), .pos_out(pos), .probe_out(pr));
  tpc_capture dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .position_in(pos), .homing_in(hm),
    .enc_index_in(pr[0]), .enc_strobe_in(pr[1]), .enc_zero_in(pr[2]), .aux_src_in(pr[4:3]),
    .obj_wr_in(w), .obj_index_in(ix), .obj_wdata_in(d), .obj_rdata_out(rd), .obj_ack_out(ack),
    .config_out(cf), .status_out(st), .p1_rise_pos_out(p1r), .p1_fall_pos_out(p1f));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic src(int c);
    case (c ? mcf_reg[11:10] : mcf_reg[3:2])
      2'h0:    return pr[c];
      2'h1:    return pr[2];
      2'h2:    return pr[3+c];
      default: return 1'b0; // Reserved source never fires
    endcase
  endfunction : src

  // Captures use the config held before this edge's write
  always @(posedge clk_in or negedge arst_n_in) begin : ref_model
    logic s, en;
    if (!arst_n_in) begin
      {mcf_reg, prv_reg, arm_reg, rf_reg, ff_reg, mr_reg, mf_reg} = '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        s  = src(c);
        en = mcf_reg[8*c] && !hm;
        if (!en || !mcf_reg[8*c+4]) rf_reg[c] = 0;
        else if (s && !prv_reg[c] && !rf_reg[c]) begin
          rf_reg[c] = 1;
          if (c == 0) mr_reg = pos;
        end
        if (!en || !mcf_reg[8*c+5]) ff_reg[c] = 0;
        else if (!s && prv_reg[c] && arm_reg[c] && !ff_reg[c]) begin
          ff_reg[c] = 1;
          if (c == 0) mf_reg = pos;
        end
        arm_reg[c] = en && (arm_reg[c] || (s && !prv_reg[c]));
        prv_reg[c] = s;
      end
      if (w && ix == TPC_IDX_CONFIG) mcf_reg = d[15:0];
    end
  end

  // ----------------------------------------
  // Comparison at every falling edge
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  always @(negedge clk_in) begin : compare
    logic [15:0] es;
    logic [31:0] er;
    es = {mcf_reg[15:14], 3'h0, ff_reg[1], rf_reg[1], mcf_reg[8] & !hm,
          mcf_reg[7:6], 3'h0, ff_reg[0], rf_reg[0], mcf_reg[0] & !hm};
    case (ix)
      TPC_IDX_CONFIG:  er = {16'h0000, mcf_reg};
      TPC_IDX_STATUS:  er = {16'h0000, es};
      TPC_IDX_P1_RISE: er = mr_reg;
      TPC_IDX_P1_FALL: er = mf_reg;
      default:         er = 32'h0000_0000;
    endcase
    if (arst_n_in) begin
      check("config", {16'h0000, cf}, {16'h0000, mcf_reg});
      check("status", {16'h0000, st}, {16'h0000, es});
      check("rise pos", p1r, mr_reg);
      check("fall pos", p1f, mf_reg);
      check("read data", rd, er);
      check("mapped", {31'h0, ack}, {31'h0, (ix inside {[TPC_IDX_CONFIG:TPC_IDX_P1_FALL]})});
    end
  end

  // ----------------------------------------
  // Drivers and run control
  // ----------------------------------------
  task wr(input logic [15:0] i, input logic [15:0] v);
    @(posedge clk_in);
    #2;
    w = 1;
    ix = i;
    d = {16'h0000, v};
    @(posedge clk_in);
    #2;
    w = 0;
  endtask : wr

  task pin(input logic [4:0] l, input logic h, input int n);
    @(posedge clk_in);
    #2;
    lv = l;
    hm = h;
    repeat (n) @(posedge clk_in);
  endtask : pin

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Whole run is about 3200 cycles; allow three times that
  initial begin
    #500000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(98557));
    repeat (16) @(posedge clk_in);
    #2 arst_n_in = 1;
    // Capture both edges, re-arm rising, writes to read-only objects, disable
    wr(TPC_IDX_CONFIG, 16'h0031); pin(5'h01, 0, 4); pin(5'h00, 0, 4);
    wr(TPC_IDX_CONFIG, 16'h0021); wr(TPC_IDX_CONFIG, 16'h0031); pin(5'h01, 0, 4); pin(5'h00, 0, 4);
    wr(TPC_IDX_STATUS, 16'hFFFF); wr(TPC_IDX_P1_RISE, 16'h1234); wr(TPC_IDX_CONFIG, 16'h0030); pin(5'h00, 0, 3);
    $display("test walk done");
    // Input high at enable: first falling edge must be ignored
    pin(5'h03, 0, 3); wr(TPC_IDX_CONFIG, 16'hF1F1); pin(5'h00, 0, 4); pin(5'h03, 0, 4); pin(5'h00, 0, 4);
    $display("test first fall done");
    // Every trigger source code, then homing suppresses capture
    // Channels off first so stored flags clear and each source but the reserved code captures afresh
    for (int s = 0; s < 4; s++) begin
      wr(TPC_IDX_CONFIG, 16'h0000);
      wr(TPC_IDX_CONFIG, 16'h3131 | 16'(s << 2) | 16'(s << 10));
      pin((s == 0) ? 5'h03 : (s == 1) ? 5'h04 : (s == 2) ? 5'h18 : 5'h1F, 0, 3);
      pin(5'h00, 0, 3);
    end
    wr(TPC_IDX_CONFIG, 16'h3131); pin(5'h1F, 1, 3); pin(5'h00, 1, 3); pin(5'h00, 0, 3);
    $display("test sources done");
    // Random traffic, wandering probes and homing
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_in);
      #2;
      wander = 1;
      ix = 16'h60B6 + 16'($urandom % 8);
      w = ($urandom % 16 == 0);
      d = $urandom;
      hm = ($urandom % 64 == 0);
    end
    @(posedge clk_in);
    #2 w = 0;
    $display("test random done");
    tally_and_finish();
  end
endmodule : tpc_capture_tb_top
